// ---- design/rx_cfg_pkg.sv ----
package rx_cfg_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int GROUPS = 4;
    // register offsets
    localparam logic [7:0] LOW_POWER_CONFIG_ADDR = 8'hc8;
    localparam logic [7:0] MEDIUM_POWER_CONFIG_ADDR = 8'hce;
    localparam logic [7:0] HPF_DISCONNECT_CONFIG_ADDR = 8'he6;
    localparam logic [7:0] GAIN_MAP_CTRL_ADDR = 8'hd0;
    localparam logic [7:0] DIE_STATUS_ADDR = 8'hd2;
    // field positions
    localparam int LOW_POWER_SELECT_POS = 12;
    localparam int MID_POWER_SELECT_POS = 14;
    localparam int FILTER_DISCONNECT_SOURCE_POS = 4;
    localparam int FILTER_CONNECT_GROUP1_POS = 0;
    localparam int GAIN_MAP_WRITE_ENABLE_POS = 0;
    // register reset value (reserved bits must be written zero, stored anyway)
    localparam logic [15:0] REG_RESET = 16'h0000;
    // cutoff select: halved in low power
    localparam logic [1:0] LPF_SCALE_FULL = 2'h0;
    localparam logic [1:0] LPF_SCALE_HALF = 2'h1;

    typedef enum {MODE_LOW_NOISE, MODE_MEDIUM_POWER, MODE_LOW_POWER} power_mode_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic low_power;
        logic medium_power;
        logic lpf_half_cutoff;
        logic [3:0] hpf_connected;
        logic [3:0] hpf_powered;
    } die_ctrl_t;
endpackage : rx_cfg_pkg

// ---- design/cfg_reg16.sv ----
`timescale 1ns/100ps
module cfg_reg16
    import rx_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr,
    input wire logic [15:0] wdata,
    output logic [15:0] q
);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= REG_RESET;
        end else if (wr) begin
            q <= wdata;
        end
    end
endmodule : cfg_reg16

// ---- design/pin_sync.sv ----
`timescale 1ns/100ps
module pin_sync
    import rx_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [GROUPS:0] d,
    output logic [GROUPS:0] q
);
    logic [GROUPS:0] meta;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : pin_sync

// ---- design/rx_power_mode_hpf_ctrl.sv ----
// What this block does
// R01 - low power select bit 12 sets low power in gain compensation mode only
// R02 - mid power select bit 14 sets medium power in gain compensation mode
// R03 - software keeps low power select clear when choosing medium power
// R04 - mid power select has no effect in continuous wave mode
// R05 - source bit 4 clear: per-group pins decide filter disconnect
// R06 - source bit set: pins ignored, per-group register bits decide
// R07 - register bit 3 connects (1) or disconnects (0) channels 13 to 16
// R08 - register bit 2 connects (1) or disconnects (0) channels 9 to 12
// R09 - register bit 1 connects (1) or disconnects (0) channels 5 to 8
// R10 - register bit 0 connects (1) or disconnects (0) channels 1 to 4
// R11 - disconnected filter stays powered, only separated from input
// R12 - software sets gain map write enable before other gain map writes
// R13 - low power halves the anti-alias cutoff for the same code
// R14 - registers reset to zero and read back last value written
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
module rx_power_mode_hpf_ctrl
    import rx_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    input wire logic continuous_wave_mode,
    input wire logic [3:0] group_disconnect_pin,
    output logic [3:0] hpf_connect,
    output logic [3:0] hpf_power,
    output logic low_power_active,
    output logic medium_power_active,
    output logic [1:0] lpf_cutoff_scale,
    output logic gain_map_write_enable
);
    logic rst_meta;
    logic rst_n;
    reg_req_t req;
    logic [15:0] low_power_config;
    logic [15:0] medium_power_config;
    logic [15:0] hpf_disconnect_config;
    logic [15:0] gain_map_ctrl;
    logic [GROUPS:0] sync_q;
    logic cw_mode;
    logic [3:0] pins_s;
    logic [15:0] status_word;
    logic [15:0] next_rdata;
    power_mode_t mode;
    die_ctrl_t ctrl;
    logic outputs_live;
    wire [3:0] conn_sel;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // outputs carry real values from the first edge after the internal reset lifts
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            outputs_live <= 1'b0;
        end else begin
            outputs_live <= 1'b1;
        end
    end

    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    wire wr_low = req.wr && req.addr == LOW_POWER_CONFIG_ADDR;
    wire wr_mid = req.wr && req.addr == MEDIUM_POWER_CONFIG_ADDR;
    wire wr_hpf = req.wr && req.addr == HPF_DISCONNECT_CONFIG_ADDR;
    wire wr_gmc = req.wr && req.addr == GAIN_MAP_CTRL_ADDR;

    // zero reset, written value held for readback [R14]
    cfg_reg16 u_low (.clk(clk), .rst_n(rst_n), .wr(wr_low), .wdata(req.wdata),
        .q(low_power_config));
    cfg_reg16 u_mid (.clk(clk), .rst_n(rst_n), .wr(wr_mid), .wdata(req.wdata),
        .q(medium_power_config));
    cfg_reg16 u_hpf (.clk(clk), .rst_n(rst_n), .wr(wr_hpf), .wdata(req.wdata),
        .q(hpf_disconnect_config));
    cfg_reg16 u_gmc (.clk(clk), .rst_n(rst_n), .wr(wr_gmc), .wdata(req.wdata),
        .q(gain_map_ctrl));

    pin_sync u_sync (.clk(clk), .rst_n(rst_n),
        .d({continuous_wave_mode, group_disconnect_pin}), .q(sync_q));
    assign cw_mode = sync_q[GROUPS];
    assign pins_s = sync_q[GROUPS-1:0];

    wire lp_sel = low_power_config[LOW_POWER_SELECT_POS];
    wire mp_sel = medium_power_config[MID_POWER_SELECT_POS];
    wire src_reg = hpf_disconnect_config[FILTER_DISCONNECT_SOURCE_POS];
    wire [3:0] grp_bits = hpf_disconnect_config[FILTER_CONNECT_GROUP1_POS +: GROUPS];

    // mode selection; medium needs low clear [R01] [R02] [R04]
    always_comb begin
        if (cw_mode) begin
            mode = MODE_LOW_NOISE;
        end else if (lp_sel) begin
            mode = MODE_LOW_POWER;
        end else if (mp_sel) begin
            mode = MODE_MEDIUM_POWER;
        end else begin
            mode = MODE_LOW_NOISE;
        end
    end

    always_comb begin
        ctrl = '0;
        case (mode)
            MODE_LOW_POWER: begin
                ctrl.low_power = 1'b1;
                ctrl.lpf_half_cutoff = 1'b1; // [R13]
            end
            MODE_MEDIUM_POWER: begin
                ctrl.medium_power = 1'b1;
            end
            MODE_LOW_NOISE: begin
                ctrl.low_power = 1'b0;
            end
            default: begin
                ctrl.low_power = 1'b0;
            end
        endcase
        ctrl.hpf_powered = '1; // [R11]
        ctrl.hpf_connected = conn_sel;
    end

    // per group: pins when source clear, register bits when set
    genvar g;
    generate
        for (g = 0; g < GROUPS; g++) begin : g_grp
            // pin high requests disconnect [R05] [R06] [R07] [R08] [R09] [R10]
            assign conn_sel[g] = src_reg ? grp_bits[g] : ~pins_s[g];
        end
    endgenerate

    assign status_word = {5'h00, mode == MODE_MEDIUM_POWER, mode == MODE_LOW_POWER,
        cw_mode, pins_s, ctrl.hpf_connected};

    always_comb begin
        case (req.addr)
            LOW_POWER_CONFIG_ADDR: next_rdata = low_power_config;
            MEDIUM_POWER_CONFIG_ADDR: next_rdata = medium_power_config;
            HPF_DISCONNECT_CONFIG_ADDR: next_rdata = hpf_disconnect_config;
            GAIN_MAP_CTRL_ADDR: next_rdata = gain_map_ctrl;
            DIE_STATUS_ADDR: next_rdata = status_word;
            default: next_rdata = 16'h0000;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 16'h0000;
            hpf_connect <= 4'h0;
            hpf_power <= 4'h0;
            low_power_active <= 1'b0;
            medium_power_active <= 1'b0;
            lpf_cutoff_scale <= LPF_SCALE_FULL;
            gain_map_write_enable <= 1'b0;
        end else begin
            rdata <= req.rd ? next_rdata : 16'h0000;
            hpf_connect <= ctrl.hpf_connected;
            hpf_power <= ctrl.hpf_powered;
            low_power_active <= ctrl.low_power;
            medium_power_active <= ctrl.medium_power;
            lpf_cutoff_scale <= ctrl.lpf_half_cutoff ? LPF_SCALE_HALF : LPF_SCALE_FULL;
            gain_map_write_enable <= gain_map_ctrl[GAIN_MAP_WRITE_ENABLE_POS]; // [R12]
        end
    end

    low_in_cw_a: assert property (@(posedge clk) disable iff (!rst_n) // [R01]
        cw_mode |=> !low_power_active)
        else $error("low power active in continuous wave mode");
    low_sel_a: assert property (@(posedge clk) disable iff (!rst_n) // [R01]
        (lp_sel && !cw_mode) |=> low_power_active)
        else $error("low power select not applied");
    mid_sel_a: assert property (@(posedge clk) disable iff (!rst_n) // [R02]
        (mp_sel && !lp_sel && !cw_mode) |=> medium_power_active)
        else $error("medium power select not applied");
    mid_cw_a: assert property (@(posedge clk) disable iff (!rst_n) // [R04]
        cw_mode |=> !medium_power_active)
        else $error("medium power active in continuous wave mode");
    pin_src_a: assert property (@(posedge clk) disable iff (!outputs_live) // [R05]
        !src_reg |=> hpf_connect == ~$past(pins_s))
        else $error("pin controlled disconnect wrong");
    reg_src_a: assert property (@(posedge clk) disable iff (!rst_n) // [R06]
        src_reg |=> hpf_connect == $past(grp_bits))
        else $error("register controlled disconnect wrong");
    grp4_bit_a: assert property (@(posedge clk) disable iff (!rst_n) // [R07]
        (src_reg && !hpf_disconnect_config[3]) |=> !hpf_connect[3])
        else $error("group four not disconnected");
    grp3_bit_a: assert property (@(posedge clk) disable iff (!rst_n) // [R08]
        (src_reg && hpf_disconnect_config[2]) |=> hpf_connect[2])
        else $error("group three not connected");
    grp2_bit_a: assert property (@(posedge clk) disable iff (!rst_n) // [R09]
        (src_reg && hpf_disconnect_config[1]) |=> hpf_connect[1])
        else $error("group two not connected");
    grp1_bit_a: assert property (@(posedge clk) disable iff (!rst_n) // [R10]
        (src_reg && !hpf_disconnect_config[0]) |=> !hpf_connect[0])
        else $error("group one not disconnected");
    hpf_power_a: assert property (@(posedge clk) disable iff (!outputs_live) // [R11]
        ##1 hpf_power == 4'hf)
        else $error("filter power dropped");
    lpf_half_a: assert property (@(posedge clk) disable iff (!rst_n) // [R13]
        low_power_active |-> lpf_cutoff_scale == LPF_SCALE_HALF)
        else $error("cutoff not halved in low power");
    readback_a: assert property (@(posedge clk) disable iff (!rst_n) // [R14]
        (wr_hpf ##1 !wr ##1 (rd && addr == HPF_DISCONNECT_CONFIG_ADDR && !wr))
        |=> rdata == $past(wdata, 3))
        else $error("readback mismatch");

    // read port: data only in the cycle after a read strobe
    rd_idle_a: assert property (@(posedge clk) disable iff (!outputs_live) // [R14]
        !rd |=> rdata == 16'h0000)
        else $error("read data outside read cycle");
    unmapped_rd_a: assert property (@(posedge clk) disable iff (!outputs_live) // [R14]
        (rd && addr != LOW_POWER_CONFIG_ADDR && addr != MEDIUM_POWER_CONFIG_ADDR
            && addr != HPF_DISCONNECT_CONFIG_ADDR && addr != GAIN_MAP_CTRL_ADDR
            && addr != DIE_STATUS_ADDR) |=> rdata == 16'h0000)
        else $error("unmapped read not zero");
    low_rb_a: assert property (@(posedge clk) disable iff (!outputs_live) // [R14]
        (wr_low ##1 !wr ##1 (rd && addr == LOW_POWER_CONFIG_ADDR && !wr))
        |=> rdata == $past(wdata, 3))
        else $error("low power register readback mismatch");
    mid_rb_a: assert property (@(posedge clk) disable iff (!outputs_live) // [R14]
        (wr_mid ##1 !wr ##1 (rd && addr == MEDIUM_POWER_CONFIG_ADDR && !wr))
        |=> rdata == $past(wdata, 3))
        else $error("medium power register readback mismatch");
    gmc_rb_a: assert property (@(posedge clk) disable iff (!outputs_live) // [R14]
        (wr_gmc ##1 !wr ##1 (rd && addr == GAIN_MAP_CTRL_ADDR && !wr))
        |=> rdata == $past(wdata, 3))
        else $error("gain map control readback mismatch");
    status_pad_a: assert property (@(posedge clk) disable iff (!outputs_live) // [R14]
        (rd && addr == DIE_STATUS_ADDR) |=> rdata[15:11] == 5'h00)
        else $error("status spare bits not zero");

    // status word mirrors the live outputs and the synchronised mode and disconnect pins
    status_mode_a: assert property (@(posedge clk) disable iff (!outputs_live) // [R02]
        (rd && addr == DIE_STATUS_ADDR) |=> rdata[10:9] == {medium_power_active, low_power_active})
        else $error("status mode bits wrong");
    status_cw_a: assert property (@(posedge clk) disable iff (!outputs_live) // [R04]
        (rd && addr == DIE_STATUS_ADDR) |=> rdata[8] == $past(cw_mode))
        else $error("status mode pin bit wrong");
    status_con_a: assert property (@(posedge clk) disable iff (!outputs_live) // [R05]
        (rd && addr == DIE_STATUS_ADDR) |=> rdata[3:0] == hpf_connect)
        else $error("status connect bits wrong");

    // power mode outputs follow the select bits one cycle later
    low_off_a: assert property (@(posedge clk) disable iff (!outputs_live) // [R01]
        !lp_sel |=> !low_power_active)
        else $error("low power active without select");
    mid_off_a: assert property (@(posedge clk) disable iff (!outputs_live) // [R02]
        !mp_sel |=> !medium_power_active)
        else $error("medium power active without select");
    mid_low_a: assert property (@(posedge clk) disable iff (!outputs_live) // [R02]
        lp_sel |=> !medium_power_active)
        else $error("medium power active beside low power select");
    cw_full_a: assert property (@(posedge clk) disable iff (!outputs_live) // [R13]
        cw_mode |=> lpf_cutoff_scale == LPF_SCALE_FULL)
        else $error("cutoff halved in continuous wave mode");
    lpf_lp_a: assert property (@(posedge clk) disable iff (!outputs_live) // [R13]
        (lp_sel && !cw_mode) |=> lpf_cutoff_scale == LPF_SCALE_HALF)
        else $error("cutoff not halved for low power select");
    lpf_full_a: assert property (@(posedge clk) disable iff (!outputs_live) // [R13]
        !low_power_active |-> lpf_cutoff_scale == LPF_SCALE_FULL)
        else $error("cutoff halved outside low power");
    cw_sync_a: assert property (@(posedge clk) disable iff (!outputs_live) // [R04]
        ##2 cw_mode == $past(continuous_wave_mode, 2))
        else $error("mode pin not passed through two stages");

    // filter connect outputs, second polarity of each register bit
    grp4_on_a: assert property (@(posedge clk) disable iff (!outputs_live) // [R07]
        (src_reg && hpf_disconnect_config[3]) |=> hpf_connect[3])
        else $error("group four not connected");
    grp3_off_a: assert property (@(posedge clk) disable iff (!outputs_live) // [R08]
        (src_reg && !hpf_disconnect_config[2]) |=> !hpf_connect[2])
        else $error("group three not disconnected");
    grp2_off_a: assert property (@(posedge clk) disable iff (!outputs_live) // [R09]
        (src_reg && !hpf_disconnect_config[1]) |=> !hpf_connect[1])
        else $error("group two not disconnected");
    grp1_on_a: assert property (@(posedge clk) disable iff (!outputs_live) // [R10]
        (src_reg && hpf_disconnect_config[0]) |=> hpf_connect[0])
        else $error("group one not connected");
    pins_held_a: assert property (@(posedge clk) disable iff (!outputs_live) // [R06]
        (src_reg && $past(src_reg) && $stable(grp_bits)) |=> $stable(hpf_connect))
        else $error("pins moved a register controlled filter");
    pins_sync_a: assert property (@(posedge clk) disable iff (!outputs_live) // [R05]
        ##2 pins_s == $past(group_disconnect_pin, 2))
        else $error("disconnect pins not passed through two stages");
    wme_copy_a: assert property (@(posedge clk) disable iff (!outputs_live) // [R12]
        1'b1 |=> gain_map_write_enable == $past(gain_map_ctrl[GAIN_MAP_WRITE_ENABLE_POS]))
        else $error("write enable output does not follow its bit");

    // each group disconnects when its own pin is high while the pins are the source
    generate
        for (g = 0; g < GROUPS; g++) begin : g_pin_chk
            pin_grp_a: assert property (@(posedge clk) disable iff (!outputs_live) // [R05]
                (!src_reg && pins_s[g]) |=> !hpf_connect[g])
                else $error("pin high did not disconnect its group");
        end
    endgenerate
endmodule : rx_power_mode_hpf_ctrl

// ---- tb/rx_power_mode_hpf_ctrl_tb.sv ----
`timescale 1ns/100ps
module rx_power_mode_hpf_ctrl_tb;
    import rx_cfg_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic cw = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic [3:0] pins = 4'h0;
    logic [15:0] rdata;
    logic [3:0] hpf_connect;
    logic [3:0] hpf_power;
    logic low_power_active;
    logic medium_power_active;
    logic [1:0] lpf_cutoff_scale;
    logic gain_map_write_enable;
    logic [15:0] lfsr = 16'h0037;
    logic lp;
    logic mp;
    logic c;
    logic [4:0] hr;
    logic [3:0] p;
    logic [15:0] ex;
    int bad_count = 0;
    int n_compared = 0;
    wire [15:0] seen = {4'h0, low_power_active, medium_power_active, lpf_cutoff_scale,
                        hpf_power, hpf_connect};

    rx_power_mode_hpf_ctrl i_dut (
        .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .continuous_wave_mode(cw), .group_disconnect_pin(pins),
        .hpf_connect(hpf_connect), .hpf_power(hpf_power),
        .low_power_active(low_power_active), .medium_power_active(medium_power_active),
        .lpf_cutoff_scale(lpf_cutoff_scale), .gain_map_write_enable(gain_map_write_enable)
    );

    always #5 clk = ~clk;

    function automatic logic [15:0] next_rand(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : next_rand

    // low power wins over medium; pins high mean disconnect
    function automatic logic [15:0] expect_out(input logic l, input logic m, input logic [4:0] h,
                                               input logic cwm, input logic [3:0] pin);
        logic lo;
        logic [3:0] con;
        lo = l & ~cwm;
        con = h[4] ? h[3:0] : ~pin;
        return {4'h0, lo, m & ~l & ~cwm, 1'b0, lo, 4'hf, con};
    endfunction : expect_out

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : reg_write

    task automatic reg_check(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(rdata, exp);
    endtask : reg_check

    task automatic stop_test;
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test

    initial begin
        #200000;
        bad_count++;
        stop_test();
    end

    initial begin
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        repeat (6) @(posedge clk);
        reg_check(LOW_POWER_CONFIG_ADDR, 16'h0000);
        reg_check(MEDIUM_POWER_CONFIG_ADDR, 16'h0000);
        reg_check(HPF_DISCONNECT_CONFIG_ADDR, 16'h0000);
        reg_check(GAIN_MAP_CTRL_ADDR, 16'h0000);
        check(seen, expect_out(1'b0, 1'b0, 5'h00, 1'b0, 4'h0));
        $display("reset test done");
        // first eight passes walk the legal mode combinations, the rest are random
        for (int i = 0; i < 24; i++) begin
            lfsr = next_rand(lfsr);
            mp = (i < 8) ? i[2] : lfsr[1];
            lp = ((i < 8) ? i[1] : lfsr[0]) & ~mp;
            c = (i < 8) ? i[0] : lfsr[2];
            hr = lfsr[8:4];
            p = lfsr[15:12];
            ex = expect_out(lp, mp, hr, c, p);
            @(posedge clk);
            cw <= c;
            pins <= p;
            reg_write(mp ? LOW_POWER_CONFIG_ADDR : MEDIUM_POWER_CONFIG_ADDR, 16'h0000);
            reg_write(mp ? MEDIUM_POWER_CONFIG_ADDR : LOW_POWER_CONFIG_ADDR,
                      {1'b0, mp, 1'b0, lp, 12'h000});
            reg_write(HPF_DISCONNECT_CONFIG_ADDR, {11'h000, hr});
            repeat (6) @(posedge clk);
            #1;
            check({8'h00, seen[15:8]}, {8'h00, ex[15:8]});
            check({12'h000, seen[7:4]}, {12'h000, ex[7:4]});
            check({12'h000, seen[3:0]}, {12'h000, ex[3:0]});
            reg_check(LOW_POWER_CONFIG_ADDR, {3'h0, lp, 12'h000});
            reg_check(MEDIUM_POWER_CONFIG_ADDR, {1'b0, mp, 14'h0000});
            reg_check(HPF_DISCONNECT_CONFIG_ADDR, {11'h000, hr});
            reg_check(DIE_STATUS_ADDR, {5'h00, ex[10], ex[11], c, p, ex[3:0]});
        end
        $display("mode and filter test done");
        reg_write(LOW_POWER_CONFIG_ADDR, 16'h0000);
        reg_check(LOW_POWER_CONFIG_ADDR, 16'h0000);
        reg_write(MEDIUM_POWER_CONFIG_ADDR, 16'h4000);
        reg_check(MEDIUM_POWER_CONFIG_ADDR, 16'h4000);
        reg_write(HPF_DISCONNECT_CONFIG_ADDR, 16'h0015);
        reg_check(HPF_DISCONNECT_CONFIG_ADDR, 16'h0015);
        reg_write(GAIN_MAP_CTRL_ADDR, 16'h0001);
        reg_check(GAIN_MAP_CTRL_ADDR, 16'h0001);
        repeat (3) @(posedge clk);
        #1;
        check({15'h0, gain_map_write_enable}, 16'h0001);
        reg_write(GAIN_MAP_CTRL_ADDR, 16'h0000);
        reg_write(8'h55, 16'hffff);
        reg_check(8'h55, 16'h0000);
        repeat (3) @(posedge clk);
        #1;
        check({15'h0, gain_map_write_enable}, 16'h0000);
        $display("gain map and unmapped test done");
        stop_test();
    end
endmodule : rx_power_mode_hpf_ctrl_tb
